// >>> rtl/iacl_filter.sv
// Contract
// - one filter instance per ingress port
// - sixteen entries: match, action, processing each
// - three independent rule kinds
// - result steers forwarding map and priority
// - counter mode: 11-bit count from action
// - counter entry pairs match and action index
// - watchdog interrupt when matching packet missing
// - event interrupt after programmed packet count
// - 16-bit select mask, selected results ANDed
// - 4-bit action pointer per processing entry
// - same pointer from several entries ORed
// - all rules evaluated, entry 0 highest
// - one action, lowest pointer wins
// - layer2 option00 counts MAC plus EtherType
// - layer2 options: type, MAC, both
// - layer3 masked address, address pair, reserved
// - layer4 protocol, TCP, UDP ports, sequence
// - TCP flag compare under programmable mask
// - mode 00 rule never true
// - time unit bit: microsecond or millisecond
// - watchdog loads, decrements, interrupts on expiry
// - event counter increments, interrupts, then resets
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module iacl_filter
  import iacl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire iacl_pkt_t pkt,
  input wire iacl_lookup_t lookup,
  output iacl_decision_t decision,
  output logic count_irq,
  output logic [N_ENT-1:0] count_flags
);

  // ****************************************
  // rule evaluation
  // ****************************************
  function automatic logic port_ok(input logic [31:0] ctl, input logic [31:0] a, input logic [15:0] p);
    logic [15:0] hi;
    logic [15:0] lo;
    logic inr;
    hi = a[31:16];
    lo = a[15:0];
    inr = (p >= lo) && (p <= hi);
    case (ctl[F_PC +: 2])
      PC_OFF: port_ok = 1'b1;
      PC_EITHER: port_ok = (p == hi) || (p == lo);
      PC_IN: port_ok = inr;
      default: port_ok = !inr;
    endcase
  endfunction : port_ok

  function automatic logic [1:0] l2_cmp(input logic [31:0] ctl, input logic [31:0] a, input logic [31:0] b,
                                        input iacl_pkt_t p);
    logic [47:0] mac;
    mac = ctl[F_SD] ? p.smac : p.dmac;
    l2_cmp = {mac == {b[31:16], a}, p.etype == b[15:0]};
  endfunction : l2_cmp

  function automatic logic rule_hit(input logic [31:0] ctl, input logic [31:0] a, input logic [31:0] b,
                                    input iacl_pkt_t p);
    logic [1:0] l2;
    logic [31:0] ip;
    logic [15:0] port;
    logic [5:0] fmsk;
    logic cmp;
    logic ok;
    l2 = l2_cmp(ctl, a, b, p);
    ip = ctl[F_SD] ? p.sip : p.dip;
    port = ctl[F_SD] ? p.sport : p.dport;
    fmsk = ctl[F_FMSK +: 6];
    cmp = 1'b0;
    ok = 1'b1;
    case (ctl[F_MODE +: 2])
      MD_L2: begin
        case (ctl[F_OPT +: 2])
          L2_TYPE: cmp = l2[0];
          L2_MAC: cmp = l2[1];
          L2_BOTH: cmp = &l2;
          default: ok = 1'b0;
        endcase
      end
      MD_L3: begin
        case (ctl[F_OPT +: 2])
          L3_MASKED: cmp = p.ipv4 && (((ip ^ a) & ~b) == RST_WORD);
          L3_PAIR: cmp = p.ipv4 && (p.sip == a) && (p.dip == b);
          default: ok = 1'b0;
        endcase
      end
      MD_L4: begin
        case (ctl[F_OPT +: 2])
          L4_PROTO: cmp = p.ipv4 && (p.proto == ctl[F_PROTO +: 8]);
          L4_TCP: cmp = p.tcp && port_ok(ctl, a, port);
          L4_UDP: cmp = p.udp && port_ok(ctl, a, port);
          default: cmp = p.tcp && (p.seq == a);
        endcase
        if (ctl[F_FME] && p.tcp) begin
          cmp = cmp && (((p.flags ^ ctl[F_FVAL +: 6]) & fmsk) == 6'h00);
        end
      end
      default: ok = 1'b0;
    endcase
    rule_hit = ok && (ctl[F_EQ] ? cmp : !cmp);
  endfunction : rule_hit

  iacl_state_t st_r;
  iacl_state_t st_nxt;
  logic [N_ENT-1:0] hit;
  logic [N_ENT-1:0] qual;
  logic [N_ENT-1:0] pe_true;
  logic [N_ENT-1:0] act_req;
  logic [N_ENT-1:0] is_cnt;
  logic [N_ENT-1:0] flag_clr;
  logic [IDX_W-1:0] sel;
  logic addr_ok;

  // every rule sees every packet; the instance serves one port
  for (genvar gi = 0; gi < N_ENT; gi++) begin : g_rule
    assign hit[gi] = pkt.valid && rule_hit(st_r.mctl[gi], st_r.ma[gi], st_r.mb[gi], pkt);
    assign is_cnt[gi] = (st_r.mctl[gi][F_MODE +: 2] == MD_L2) && (st_r.mctl[gi][F_OPT +: 2] == L2_COUNT);
    assign qual[gi] = pkt.valid && is_cnt[gi] && (&l2_cmp(st_r.mctl[gi], st_r.ma[gi], st_r.mb[gi], pkt));
    assign pe_true[gi] = (st_r.proc[gi][P_MASK +: N_ENT] != '0) &&
                         ((hit & st_r.proc[gi][P_MASK +: N_ENT]) == st_r.proc[gi][P_MASK +: N_ENT]);
  end

  // ****************************************
  // action selection
  // ****************************************
  always_comb begin
    act_req = '0;
    for (int j = 0; j < N_ENT; j++) begin
      if (pe_true[j]) begin
        act_req[st_r.proc[j][P_PTR +: IDX_W]] = 1'b1;
      end
    end
    sel = '0;
    for (int k = N_ENT - 1; k >= 0; k--) begin
      if (act_req[k]) begin
        sel = IDX_W'(k);
      end
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  assign addr_ok = (haddr[31:ADDR_TOP] == '0) && (haddr[ADDR_TOP-1:ADDR_LSB+4] <= RGN_MISC);
  assign flag_clr = (st_r.wr_pend && st_r.wr_idx == {RGN_MISC, MISC_FLAG}) ? hwdata[N_ENT-1:0] : '0;

  function automatic logic [31:0] rd_mux(input iacl_state_t s, input logic [7:0] idx);
    logic [3:0] e;
    e = idx[3:0];
    case (idx[7:4])
      RGN_MCTL: rd_mux = s.mctl[e];
      RGN_MA: rd_mux = s.ma[e];
      RGN_MB: rd_mux = s.mb[e];
      RGN_ACT: rd_mux = s.act[e];
      RGN_PROC: rd_mux = s.proc[e];
      RGN_MISC: begin
        case (e)
          MISC_CTRL: rd_mux = {31'h0000_0000, s.en};
          MISC_FLAG: rd_mux = {16'h0000, s.flags};
          MISC_LAST: rd_mux = {26'h000_0000, s.dec.hit, s.dec.act_idx, s.dec.valid};
          default: rd_mux = RST_WORD;
        endcase
      end
      default: rd_mux = RST_WORD;
    endcase
  endfunction : rd_mux

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [CNT_W-1:0] cv;
    logic [CNT_W-1:0] inc;
    logic tick;
    cv = '0;
    inc = '0;
    tick = 1'b0;
    st_nxt = st_r;
    st_nxt.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      st_nxt.wr_pend = hwrite && addr_ok;
      st_nxt.wr_idx = haddr[ADDR_TOP-1:ADDR_LSB];
      st_nxt.rd_wait = !hwrite;
      st_nxt.rd_idx = addr_ok ? haddr[ADDR_TOP-1:ADDR_LSB] : {RGN_MISC, 4'hf};
    end
    if (st_r.rd_wait) begin
      // one wait state lets a read follow a write to the same word
      st_nxt.rd_wait = 1'b0;
      st_nxt.rdata = rd_mux(st_r, st_r.rd_idx);
    end
    if (st_r.wr_pend) begin
      case (st_r.wr_idx[7:4])
        RGN_MCTL: st_nxt.mctl[st_r.wr_idx[3:0]] = hwdata;
        RGN_MA: st_nxt.ma[st_r.wr_idx[3:0]] = hwdata;
        RGN_MB: st_nxt.mb[st_r.wr_idx[3:0]] = hwdata;
        RGN_ACT: st_nxt.act[st_r.wr_idx[3:0]] = hwdata;
        RGN_PROC: st_nxt.proc[st_r.wr_idx[3:0]] = hwdata;
        default: begin
          if (st_r.wr_idx[3:0] == MISC_CTRL) begin
            st_nxt.en = hwdata[0];
          end
        end
      endcase
    end

    // time base for watchdog counters
    st_nxt.us_tick = 1'b0;
    st_nxt.ms_tick = 1'b0;
    if (st_r.us_pre == US_W'(US_CYC - 1)) begin
      st_nxt.us_pre = '0;
      st_nxt.us_tick = 1'b1;
      st_nxt.ms_pre = (st_r.ms_pre == MS_W'(MS_US - 1)) ? '0 : st_r.ms_pre + 1'b1;
      st_nxt.ms_tick = (st_r.ms_pre == MS_W'(MS_US - 1));
    end else begin
      st_nxt.us_pre = st_r.us_pre + 1'b1;
    end

    // set wins over a software clear in the same cycle
    st_nxt.flags = st_r.flags & ~flag_clr;
    for (int i = 0; i < N_ENT; i++) begin
      cv = st_r.act[i][A_CNT +: CNT_W];
      inc = st_r.cnt[i] + CNT_ONE;
      tick = st_r.act[i][A_TU] ? st_r.ms_tick : st_r.us_tick;
      if (!is_cnt[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.act[i][A_CA]) begin
        if (qual[i]) begin
          if (inc == cv) begin
            st_nxt.cnt[i] = '0;
            st_nxt.flags[i] = 1'b1;
          end else begin
            st_nxt.cnt[i] = inc;
          end
        end
      end else if (qual[i]) begin
        st_nxt.cnt[i] = cv;
      end else if (tick && st_r.cnt[i] != '0) begin
        st_nxt.cnt[i] = st_r.cnt[i] - CNT_ONE;
        if (st_r.cnt[i] == CNT_ONE) begin
          st_nxt.flags[i] = 1'b1;
        end
      end
    end

    // decision registered one cycle after the header
    st_nxt.dec.valid = pkt.valid;
    st_nxt.dec.hit = pkt.valid && st_r.en && (act_req != '0);
    st_nxt.dec.act_idx = sel;
    st_nxt.dec.map = lookup.map;
    st_nxt.dec.prio = lookup.prio;
    if (st_nxt.dec.hit) begin
      if (st_r.act[sel][A_MAP_EN]) begin
        st_nxt.dec.map = st_r.act[sel][A_MAP +: 8];
      end
      if (st_r.act[sel][A_PRIO_EN]) begin
        st_nxt.dec.prio = st_r.act[sel][A_PRIO +: 3];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = !st_r.rd_wait;
  assign hresp = 1'b0;
  assign decision = st_r.dec;
  assign count_flags = st_r.flags;
  assign count_irq = |st_r.flags;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_result_timing: assert property (pkt.valid |=> decision.valid) else $error("decision late");
  a_no_hit_pass: assert property (pkt.valid && (act_req == '0) |=> !decision.hit && decision.map == $past(lookup.map)
    && decision.prio == $past(lookup.prio)) else $error("lookup not kept on miss");
  // entries below are the ones the bench programs, so each antecedent is reached
  a_lowest_ptr: assert property (pkt.valid && st_r.en && act_req[2] |=> decision.hit && decision.act_idx <= 4'h2)
    else $error("lowest action not chosen");
  a_mode_off: assert property (st_r.mctl[4][F_MODE +: 2] == MD_OFF |-> !hit[4]) else $error("disabled rule hit");
  a_l3_reserved: assert property (st_r.mctl[6][F_MODE +: 2] == MD_L3 &&
    (st_r.mctl[6][F_OPT +: 2] == 2'h0 || st_r.mctl[6][F_OPT +: 2] == 2'h3) |-> !hit[6])
    else $error("reserved option hit");
  a_or_entries: assert property (pkt.valid && st_r.en && pe_true[3] && st_r.proc[3][P_PTR +: IDX_W] == 4'h2
    |=> decision.hit && decision.act_idx <= 4'h2) else $error("true entry gave no action");
  a_wd_expire: assert property (is_cnt[10] && !st_r.act[10][A_CA] && !qual[10] && st_r.us_tick
    && !st_r.act[10][A_TU] && st_r.cnt[10] == CNT_ONE |=> st_r.flags[10] && st_r.cnt[10] == '0)
    else $error("watchdog expiry lost");
  a_evt_wrap: assert property (is_cnt[8] && st_r.act[8][A_CA] && qual[8] &&
    (st_r.cnt[8] + CNT_ONE) == st_r.act[8][A_CNT +: CNT_W]
    |=> st_r.cnt[8] == '0 && st_r.flags[8] ##1 count_irq || !st_r.flags[8]) else $error("event count wrap");
  a_flag_hold: assert property (st_r.flags[8] && !flag_clr[8] |=> st_r.flags[8]) else $error("flag dropped");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");

  // ****************************************
  // checks on counters, compares, time base and decision strobe
  // ****************************************
  a_cnt_no_hit: assert property (is_cnt[8] |-> !hit[8])
    else $error("counter rule gave a match");
  a_evt_step: assert property (is_cnt[8] && st_r.act[8][A_CA] && qual[8] &&
    (st_r.cnt[8] + CNT_ONE) != st_r.act[8][A_CNT +: CNT_W]
    |=> st_r.cnt[8] == $past(st_r.cnt[8]) + CNT_ONE) else $error("event count step");
  a_wd_load: assert property (is_cnt[10] && !st_r.act[10][A_CA] && qual[10]
    |=> st_r.cnt[10] == $past(st_r.act[10][A_CNT +: CNT_W]))
    else $error("watchdog load lost");
  // a millisecond tick only on a microsecond boundary, so units nest
  a_ms_on_us: assert property (st_r.ms_tick |-> st_r.us_tick)
    else $error("millisecond tick off boundary");
  a_l2_type: assert property (pkt.valid && st_r.mctl[1][F_MODE +: 2] == MD_L2 &&
    st_r.mctl[1][F_OPT +: 2] == L2_TYPE && st_r.mctl[1][F_EQ] |-> hit[1] == (pkt.etype == st_r.mb[1][15:0]))
    else $error("type compare wrong");
  a_flag_mask: assert property (pkt.valid && pkt.tcp && st_r.mctl[7][F_MODE +: 2] == MD_L4 &&
    st_r.mctl[7][F_EQ] && st_r.mctl[7][F_FME] &&
    (((pkt.flags ^ st_r.mctl[7][F_FVAL +: 6]) & st_r.mctl[7][F_FMSK +: 6]) != 6'h00) |-> !hit[7])
    else $error("flag mismatch still hit");
  a_valid_pulse: assert property (!pkt.valid |=> !decision.valid)
    else $error("decision without header");

  c_hit: cover property (decision.valid && decision.hit);
  c_multi: cover property (pkt.valid && $countones(act_req) > 1);
  c_irq: cover property ($rose(count_irq));
  c_read: cover property (!hreadyout ##1 hreadyout);
  c_watchdog: cover property (is_cnt[10] && st_r.us_tick && st_r.cnt[10] == CNT_ONE);

endmodule : iacl_filter

`default_nettype wire

// >>> rtl/iacl_pkg.sv
package iacl_pkg;

  // ****************************************
  // table geometry and word map
  // ****************************************
  localparam int N_ENT = 16;
  localparam int IDX_W = 4;
  localparam int CNT_W = 11;
  localparam logic [3:0] RGN_MCTL = 4'h0;
  localparam logic [3:0] RGN_MA = 4'h1;
  localparam logic [3:0] RGN_MB = 4'h2;
  localparam logic [3:0] RGN_ACT = 4'h3;
  localparam logic [3:0] RGN_PROC = 4'h4;
  localparam logic [3:0] RGN_MISC = 4'h5;
  localparam logic [3:0] MISC_CTRL = 4'h0;
  localparam logic [3:0] MISC_FLAG = 4'h1;
  localparam logic [3:0] MISC_LAST = 4'h2;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_TOP = 10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int F_MODE = 0;
  localparam int F_OPT = 2;
  localparam int F_SD = 4;
  localparam int F_EQ = 5;
  localparam int F_PC = 6;
  localparam int F_FME = 8;
  localparam int F_FVAL = 9;
  localparam int F_FMSK = 15;
  localparam int F_PROTO = 21;
  localparam int A_MAP = 0;
  localparam int A_PRIO = 8;
  localparam int A_MAP_EN = 11;
  localparam int A_PRIO_EN = 12;
  localparam int A_CNT = 0;
  localparam int A_TU = 11;
  localparam int A_CA = 12;
  localparam int P_MASK = 0;
  localparam int P_PTR = 16;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] MD_OFF = 2'h0;
  localparam logic [1:0] MD_L2 = 2'h1;
  localparam logic [1:0] MD_L3 = 2'h2;
  localparam logic [1:0] MD_L4 = 2'h3;
  localparam logic [1:0] L2_COUNT = 2'h0;
  localparam logic [1:0] L2_TYPE = 2'h1;
  localparam logic [1:0] L2_MAC = 2'h2;
  localparam logic [1:0] L2_BOTH = 2'h3;
  localparam logic [1:0] L3_MASKED = 2'h1;
  localparam logic [1:0] L3_PAIR = 2'h2;
  localparam logic [1:0] L4_PROTO = 2'h0;
  localparam logic [1:0] L4_TCP = 2'h1;
  localparam logic [1:0] L4_UDP = 2'h2;
  localparam logic [1:0] L4_SEQ = 2'h3;
  localparam logic [1:0] PC_OFF = 2'h0;
  localparam logic [1:0] PC_EITHER = 2'h1;
  localparam logic [1:0] PC_IN = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_US = 1000;
  localparam int US_W = 5;
  localparam int MS_W = 10;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [15:0] etype;
    logic ipv4;
    logic [31:0] dip;
    logic [31:0] sip;
    logic [7:0] proto;
    logic tcp;
    logic udp;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [31:0] seq;
    logic [5:0] flags;
  } iacl_pkt_t;

  typedef struct packed {
    logic [7:0] map;
    logic [2:0] prio;
  } iacl_lookup_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [3:0] act_idx;
    logic [7:0] map;
    logic [2:0] prio;
  } iacl_decision_t;

  typedef struct packed {
    logic [N_ENT-1:0][31:0] mctl;
    logic [N_ENT-1:0][31:0] ma;
    logic [N_ENT-1:0][31:0] mb;
    logic [N_ENT-1:0][31:0] act;
    logic [N_ENT-1:0][31:0] proc;
    logic en;
    logic [N_ENT-1:0] flags;
    logic [N_ENT-1:0][CNT_W-1:0] cnt;
    logic [US_W-1:0] us_pre;
    logic [MS_W-1:0] ms_pre;
    logic us_tick;
    logic ms_tick;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic rd_wait;
    logic [7:0] rd_idx;
    logic [31:0] rdata;
    iacl_decision_t dec;
  } iacl_state_t;

endpackage : iacl_pkg

// >>> verif/iacl_hdr_src.sv
`timescale 1ns/1ps
`default_nettype none

module iacl_hdr_src
  import iacl_pkg::*;
(
  input wire logic hclk,
  output var iacl_pkt_t pkt,
  output var iacl_lookup_t lookup
);

  // ****************************************
  // header source: one strobe per header
  // ****************************************
  initial begin
    pkt = '0;
    lookup = '0;
  end

  task automatic send(input iacl_pkt_t p, input iacl_lookup_t l);
    iacl_pkt_t q;
    q = p;
    q.valid = 1'b1;
    @(posedge hclk);
    pkt <= q;
    lookup <= l;
    @(posedge hclk);
    // fields are junk outside the strobe, so nothing can lean on stale values
    pkt <= {1'b0, ~q[$bits(q)-2:0]};
    lookup <= ~l;
  endtask : send

endmodule : iacl_hdr_src

`default_nettype wire

// >>> verif/ingress_acl_filter_engine_test.sv
`timescale 1ns/1ps
`default_nettype none

module ingress_acl_filter_engine_test import iacl_pkg::*;;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, count_irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [N_ENT-1:0] count_flags;
  iacl_pkt_t pkt;
  iacl_lookup_t lookup;
  iacl_decision_t decision, dv;
  int err_count, comparisons;
  localparam iacl_lookup_t LK = {8'h3C, 3'h1};
  localparam logic [47:0] MAC_A = 48'h0211_2233_4455;
  localparam logic [47:0] MAC_B = 48'h0211_2233_9999;
  localparam logic [47:0] MAC_C = 48'h0A0B_0C0D_0E0F;
  localparam logic [47:0] MAC_D = 48'h0A0B_1111_2222;

  iacl_filter dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pkt(pkt), .lookup(lookup), .decision(decision),
    .count_irq(count_irq), .count_flags(count_flags));

  iacl_hdr_src part_u (.hclk(hclk), .pkt(pkt), .lookup(lookup));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ****************************************
  // checking and bus helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      $display("[FAIL] hreadyout expected 1 seen stuck");
      summarize();
    end
  endtask : wait_rdy

  // address phase held until hready, then data phase held until hready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk("read word", e, q);
  endtask : rdchk

  task automatic load(input logic [43:0] c [$]);
    foreach (c[i]) wr({20'h0_0000, c[i][43:32]}, c[i][31:0]);
  endtask : load

  task automatic pk(input logic [47:0] mac, input logic [15:0] et, input logic [31:0] sip,
                    input logic [7:0] pr, input logic [5:0] fl);
    iacl_pkt_t p;
    p = '0;
    p.dmac = mac;
    p.etype = et;
    p.ipv4 = 1'b1;
    p.sip = sip;
    p.proto = pr;
    p.tcp = 1'b1;
    p.flags = fl;
    part_u.send(p, LK);
    #1;
    dv = decision;
    chk("decision valid", 32'h0000_0001, {31'h0, dv.valid});
  endtask : pk

  task automatic hitchk(input logic h, input logic [3:0] ix, input logic [7:0] m, input logic [2:0] pr);
    chk("hit", {31'h0, h}, {31'h0, dv.hit});
    chk("map prio", {21'h0, m, pr}, {21'h0, dv.map, dv.prio});
    if (h) chk("act idx", {28'h0, ix}, {28'h0, dv.act_idx});
  endtask : hitchk

  task automatic nohit;
    hitchk(1'b0, 4'h0, 8'h3C, 3'h1);
  endtask : nohit

  task automatic flchk(input logic [15:0] e);
    chk("flags irq", {15'h0, e, |e}, {15'h0, count_flags, count_irq});
  endtask : flchk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdchk(32'h0000_0000, 32'h0000_0000);
    rdchk(32'h0000_013C, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    wr(32'h0000_0180, 32'hFFFF_FFFF);
    rdchk(32'h0000_0180, 32'h0000_0000);
    pk(MAC_A, 16'h88B5, 32'h0, 8'h0, 6'h0);
    nohit();
    wr(32'h0000_0140, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset

  task automatic t_l2;
    load('{44'h000_0000_0029, 44'h040_2233_4455, 44'h080_0211_88B5, 44'h004_0000_0025,
           44'h084_0211_88B5, 44'h010_0000_002C, 44'h050_2233_4455, 44'h090_0211_88B5,
           44'h0C0_0000_1F00, 44'h0C8_0000_1A22, 44'h0D4_0000_1D55, 44'h0E4_0000_1E99,
           44'h100_0005_0001, 44'h104_0002_0003, 44'h108_0009_0002, 44'h10C_0002_0001,
           44'h110_0000_0010});
    rdchk(32'h0000_0104, 32'h0002_0003);
    pk(MAC_A, 16'h88B5, 32'h0, 8'h0, 6'h0);
    hitchk(1'b1, 4'h2, 8'h22, 3'h2);
    pk(MAC_A, 16'h0800, 32'h0, 8'h0, 6'h0);
    hitchk(1'b1, 4'h2, 8'h22, 3'h2);
    pk(MAC_B, 16'h88B5, 32'h0, 8'h0, 6'h0);
    hitchk(1'b1, 4'h9, 8'h99, 3'h6);
    pk(MAC_B, 16'h0800, 32'h0, 8'h0, 6'h0);
    nohit();
    $display("test layer2 done");
  endtask : t_l2

  task automatic t_l34;
    load('{44'h018_0000_0036, 44'h058_C0A8_0100, 44'h098_0000_00FF, 44'h01C_00C1_0523,
           44'h114_0001_0040, 44'h118_0003_0080, 44'h0C4_0000_1911, 44'h0CC_0000_1B33});
    pk(MAC_B, 16'h0800, 32'hC0A8_0177, 8'h11, 6'h00);
    hitchk(1'b1, 4'h1, 8'h11, 3'h1);
    pk(MAC_B, 16'h0800, 32'hC0A8_0277, 8'h06, 6'h12);
    hitchk(1'b1, 4'h3, 8'h33, 3'h3);
    pk(MAC_B, 16'h0800, 32'h0A00_0001, 8'h06, 6'h10);
    nohit();
    wr(32'h0000_0018, 32'h0000_003E);
    pk(MAC_B, 16'h0800, 32'hC0A8_0177, 8'h11, 6'h00);
    nohit();
    $display("test layer3 layer4 done");
  endtask : t_l34

  task automatic t_event;
    load('{44'h020_0000_0001, 44'h060_0C0D_0E0F, 44'h0A0_0A0B_88F7, 44'h0E0_0000_1003});
    for (int r = 0; r < 2; r++) begin
      repeat (2) pk(MAC_C, 16'h88F7, 32'h0, 8'h0, 6'h0);
      nohit();
      repeat (2) @(posedge hclk);
      #1;
      flchk(16'h0000);
      pk(MAC_C, 16'h88F7, 32'h0, 8'h0, 6'h0);
      repeat (2) @(posedge hclk);
      #1;
      flchk(16'h0100);
      wr(32'h0000_0144, 32'h0000_0100);
      #1;
      flchk(16'h0000);
    end
    $display("test event counter done");
  endtask : t_event

  task automatic t_watch;
    load('{44'h028_0000_0001, 44'h068_1111_2222, 44'h0A8_0A0B_88F7, 44'h0E8_0000_0004});
    pk(MAC_D, 16'h88F7, 32'h0, 8'h0, 6'h0);
    repeat (70) @(posedge hclk);
    #1;
    flchk(16'h0000);
    repeat (36) @(posedge hclk);
    #1;
    flchk(16'h0400);
    wr(32'h0000_0144, 32'h0000_0400);
    wr(32'h0000_00E8, 32'h0000_0802);
    pk(MAC_D, 16'h88F7, 32'h0, 8'h0, 6'h0);
    repeat (20000) @(posedge hclk);
    #1;
    flchk(16'h0000);
    repeat (32000) @(posedge hclk);
    #1;
    flchk(16'h0400);
    $display("test watchdog done");
  endtask : t_watch

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_l2();
    t_l34();
    t_event();
    t_watch();
    summarize();
  end

  // run-length guard against a hang
  initial begin
    #4_000_000;
    err_count++;
    $display("[FAIL] run length expected end seen hang");
    summarize();
  end

endmodule : ingress_acl_filter_engine_test

`default_nettype wire
